// ### hwpf_engine.v
// What this block does
// RULE1: streams start only after two misses within trigger distance
// RULE2: trigger distance is build parameter, 512 or 256 bytes
// RULE3: track up to 16 ascending and 4 descending streams
// RULE4: stream prefetches go memory to second-level cache
// RULE5: every miss also requests the neighbouring 64-byte line; code skips misses seen while the bus queue is busy
// RULE6: neighbour is the missed line with 64-byte bit inverted
// RULE7: look-ahead fetches next line from L2 into L1
// RULE8: prefetch requests lose to demand misses at bus queue
// RULE9: prefetches dropped when bus queue heavily occupied
// RULE10: store ownership reads treated exactly as load misses
// RULE11: software prefetch hints treated as loads
`timescale 1ns/1ps
`include "hwpf_defines.vh"
module hwpf_engine #(
    parameter TRIG_DIST = `HWPF_TRIG_DIST
) (
    input  wire        clk_sys_in,
    input  wire        rstn_in,
    input  wire        load_miss_in,
    input  wire        rfo_miss_in,
    input  wire        swpf_in,
    input  wire [31:0] miss_addr_in,
    input  wire        l1_access_in,
    input  wire [31:0] l1_addr_in,
    input  wire        demand_req_in,
    input  wire [3:0]  bus_q_level_in,
    input  wire        bus_ready_in,
    input  wire        l2_ready_in,
    output wire        bus_valid_out,
    output reg  [31:0] bus_addr_out,
    output reg  [1:0]  bus_kind_out,
    output reg         bus_to_l2_out,
    output wire        l1_pf_valid_out,
    output reg  [31:0] l1_pf_addr_out,
    output reg  [7:0]  drop_count_out
);
    // ****************
    // line helpers
    // ****************
    function [25:0] line_of;
        input [31:0] a;
        begin
            line_of = a[31:`HWPF_LINE_BIT];
        end
    endfunction

    function [25:0] pair_of;
        input [25:0] l;
        begin
            pair_of = {l[25:1], ~l[0]};
        end
    endfunction

    function [31:0] base_of;
        input [25:0] l;
        begin
            base_of = {l, {`HWPF_LINE_BIT{1'b0}}};
        end
    endfunction

    // ****************
    // trigger qualification
    // ****************
    wire miss = load_miss_in | rfo_miss_in | swpf_in; // RULE10 RULE11
    wire [25:0] line = line_of(miss_addr_in);
    reg  [25:0] prev_line;
    reg         prev_valid;
    wire        fwd_hit;
    wire        bwd_hit;
    wire [25:0] fwd_next;
    wire [25:0] bwd_next;

    hwpf_stream_table #(
        .N(`HWPF_FWD_N), .IDX_W(4), .DIR_UP(1), .DIST(TRIG_DIST) // RULE2 RULE3
    ) u_fwd (
        .clk_sys_in    (clk_sys_in),
        .rstn_in       (rstn_in),
        .miss_in       (miss),
        .line_in       (line),
        .prev_line_in  (prev_line),
        .prev_valid_in (prev_valid),
        .hit_out       (fwd_hit),
        .next_line_out (fwd_next)
    );

    hwpf_stream_table #(
        .N(`HWPF_BWD_N), .IDX_W(2), .DIR_UP(0), .DIST(TRIG_DIST) // RULE2 RULE3
    ) u_bwd (
        .clk_sys_in    (clk_sys_in),
        .rstn_in       (rstn_in),
        .miss_in       (miss),
        .line_in       (line),
        .prev_line_in  (prev_line),
        .prev_valid_in (prev_valid),
        .hit_out       (bwd_hit),
        .next_line_out (bwd_next)
    );

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_line  <= 26'h0;
            prev_valid <= 1'b0;
        end else if (miss) begin
            prev_line  <= line;
            prev_valid <= 1'b1;
        end
    end

    // ****************
    // pending prefetch slots
    // ****************
    // single slot per kind; a newer candidate overwrites, old one lost without being counted as dropped
    reg        st_pend;
    reg [25:0] st_line;
    reg        adj_pend;
    reg [25:0] adj_line;
    wire q_busy  = bus_q_level_in >= `HWPF_QHIGH;
    wire pf_gnt  = bus_ready_in && !demand_req_in; // RULE8
    wire send_st = pf_gnt && st_pend;
    wire send_adj = pf_gnt && !st_pend && adj_pend;
    wire drop_all = q_busy && (st_pend || adj_pend); // RULE9

    assign bus_valid_out = (st_pend || adj_pend) && !demand_req_in && !q_busy; // RULE8

    reg        next_st_pend;
    reg [25:0] next_st_line;
    reg        next_adj_pend;
    reg [25:0] next_adj_line;
    reg [7:0]  next_drop_count;

    always @* begin
        next_st_pend    = st_pend;
        next_st_line    = st_line;
        next_adj_pend   = adj_pend;
        next_adj_line   = adj_line;
        next_drop_count = drop_count_out;
        if (drop_all) begin
            next_st_pend    = 1'b0; // RULE9
            next_adj_pend   = 1'b0;
            next_drop_count = drop_count_out + 8'h01;
        end else begin
            if (send_st)
                next_st_pend = 1'b0;
            if (send_adj)
                next_adj_pend = 1'b0;
        end
        // a fresh miss wins over a same-cycle send of the older candidate
        if (miss && !q_busy) begin
            next_adj_pend = 1'b1;
            next_adj_line = pair_of(line); // RULE5 RULE6
            if (fwd_hit || bwd_hit) begin
                next_st_pend = 1'b1;
                next_st_line = fwd_hit ? fwd_next : bwd_next;
            end
        end
    end

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_pend        <= 1'b0;
            st_line        <= 26'h0;
            adj_pend       <= 1'b0;
            adj_line       <= 26'h0;
            drop_count_out <= 8'h00;
        end else begin
            st_pend        <= next_st_pend;
            st_line        <= next_st_line;
            adj_pend       <= next_adj_pend;
            adj_line       <= next_adj_line;
            drop_count_out <= next_drop_count;
        end
    end

    // ****************
    // bus presentation
    // ****************
    // address staged from flops; the bus must not accept on the first valid cycle
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_addr_out  <= 32'h0;
            bus_kind_out  <= `HWPF_REQ_STREAM;
            bus_to_l2_out <= 1'b1;
        end else begin
            if (st_pend) begin
                bus_addr_out <= base_of(st_line);
                bus_kind_out <= `HWPF_REQ_STREAM;
            end else begin
                bus_addr_out <= base_of(adj_line);
                bus_kind_out <= `HWPF_REQ_ADJ;
            end
            bus_to_l2_out <= 1'b1; // RULE4
        end
    end

    // ****************
    // L2 to L1 look-ahead
    // ****************
    reg        l1_pend;
    reg        next_l1_pend;
    reg [31:0] next_l1_addr;
    assign l1_pf_valid_out = l1_pend;

    // newer access replaces an unaccepted look-ahead; only the latest line pays off
    always @* begin
        next_l1_pend = l1_pend;
        next_l1_addr = l1_pf_addr_out;
        if (l1_access_in) begin
            next_l1_pend = 1'b1; // RULE7
            next_l1_addr = base_of(line_of(l1_addr_in) + 26'h1);
        end else if (l2_ready_in) begin
            next_l1_pend = 1'b0;
        end
    end

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            l1_pend        <= 1'b0;
            l1_pf_addr_out <= 32'h0;
        end else begin
            l1_pend        <= next_l1_pend;
            l1_pf_addr_out <= next_l1_addr;
        end
    end
endmodule

// ### hwpf_defines.vh
`ifndef HWPF_DEFINES_VH
`define HWPF_DEFINES_VH
`define HWPF_ADDR_W      32
`define HWPF_LINE_BIT    6
`define HWPF_SECTOR_BIT  6
`define HWPF_TRIG_DIST   512
`define HWPF_FWD_N       16
`define HWPF_BWD_N       4
`define HWPF_REQ_STREAM  2'h0
`define HWPF_REQ_ADJ     2'h1
`define HWPF_REQ_L1LA    2'h2
`define HWPF_QHIGH       4'hC
`endif

// ### hwpf_stream_table.v
`timescale 1ns/1ps
`include "hwpf_defines.vh"
// one direction of stream tracking; entries hold the last line address
module hwpf_stream_table #(
    parameter N      = 16,
    parameter IDX_W  = 4,
    parameter DIR_UP = 1,
    parameter DIST   = 512
) (
    input  wire        clk_sys_in,
    input  wire        rstn_in,
    input  wire        miss_in,
    input  wire [25:0] line_in,
    input  wire [25:0] prev_line_in,
    input  wire        prev_valid_in,
    output wire        hit_out,
    output wire [25:0] next_line_out
);
    localparam [25:0] DIST_LINES = DIST >> `HWPF_LINE_BIT;
    reg  [25:0]    last [0:N-1];
    reg  [N-1:0]   vld;
    reg  [IDX_W-1:0] rr;
    reg  [N-1:0]   match;
    integer i;
    integer j;

    // within trigger distance in this direction
    function near;
        input [25:0] a;
        input [25:0] b;
        begin
            if (DIR_UP != 0)
                near = (a > b) && ((a - b) <= DIST_LINES);
            else
                near = (a < b) && ((b - a) <= DIST_LINES);
        end
    endfunction

    always @* begin
        for (i = 0; i < N; i = i + 1)
            match[i] = vld[i] && near(line_in, last[i]);
    end

    assign hit_out       = miss_in && (|match);
    assign next_line_out = (DIR_UP != 0) ? line_in + 26'h1 : line_in - 26'h1;

    // ****************
    // allocation / advance
    // ****************
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vld <= {N{1'b0}};
            rr  <= {IDX_W{1'b0}};
        end else if (miss_in) begin
            if (|match) begin
                for (j = 0; j < N; j = j + 1)
                    if (match[j])
                        last[j] <= line_in;
            end else if (prev_valid_in && near(line_in, prev_line_in)) begin
                // second miss in range opens a stream; oldest slot replaced
                last[rr] <= line_in; // RULE1 RULE3
                vld[rr]  <= 1'b1;
                rr       <= rr + {{(IDX_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ### hwpf_engine_monitor.sv
`timescale 1ns/1ps
module hwpf_engine_monitor (
    input wire       clk_sys_in,
    input wire       rstn_in,
    input wire       load_miss_in,
    input wire       rfo_miss_in,
    input wire       swpf_in,
    input wire       l1_access_in,
    input wire       demand_req_in,
    input wire [3:0] bus_q_level_in,
    input wire       l2_ready_in,
    input wire       bus_valid_out,
    input wire       bus_to_l2_out,
    input wire       l1_pf_valid_out,
    input wire [7:0] drop_count_out
);
    // ***
    // port checks
    // ***
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    wire m  = load_miss_in | rfo_miss_in | swpf_in;
    wire ok = bus_q_level_in < 4'hC;
    AST_L2: assert property (bus_to_l2_out) else $error("fill not L2");
    AST_DEM: assert property (demand_req_in |-> !bus_valid_out) else $error("beat demand");
    AST_BUSY: assert property (!ok |-> !bus_valid_out) else $error("issued busy");
    AST_ADJ: assert property ((m && ok) ##1 (ok && !demand_req_in) |-> bus_valid_out)
        else $error("no adjacent");
    AST_L1: assert property (l1_access_in |=> l1_pf_valid_out) else $error("no look-ahead");
    AST_L1H: assert property (l1_pf_valid_out && !l2_ready_in |=> l1_pf_valid_out)
        else $error("look-ahead lost");
    AST_DROP: assert property ($changed(drop_count_out) |->
        drop_count_out == $past(drop_count_out) + 8'h01) else $error("drop step");
    AST_DROPB: assert property ($changed(drop_count_out) |-> !$past(ok)) else $error("idle drop");
endmodule
bind hwpf_engine hwpf_engine_monitor i_mon (
    .clk_sys_in      (clk_sys_in),
    .rstn_in         (rstn_in),
    .load_miss_in    (load_miss_in),
    .rfo_miss_in     (rfo_miss_in),
    .swpf_in         (swpf_in),
    .l1_access_in    (l1_access_in),
    .demand_req_in   (demand_req_in),
    .bus_q_level_in  (bus_q_level_in),
    .l2_ready_in     (l2_ready_in),
    .bus_valid_out   (bus_valid_out),
    .bus_to_l2_out   (bus_to_l2_out),
    .l1_pf_valid_out (l1_pf_valid_out),
    .drop_count_out  (drop_count_out)
);

// ### hwpf_mem_model.sv
`timescale 1ns/1ps
module hwpf_mem_model (
    input  wire        clk_sys_in,
    input  wire        stall_in,
    input  wire        valid_in,
    input  wire [33:0] req_in,
    input  wire        l1_in,
    output reg         ready_out = 1'b0,
    output reg         l2_ok_out = 1'b0
);
    // ***
    // one-cycle accept pulses, never on the first valid cycle: address is staged late
    // ***
    reg [33:0] took [$];
    always @(posedge clk_sys_in) begin
        if (valid_in && ready_out) took.push_back(req_in);
        ready_out <= valid_in && !ready_out && !stall_in;
        l2_ok_out <= l1_in && !l2_ok_out && !stall_in;
    end
endmodule

// ### hwpf_engine_tb.sv
`timescale 1ns/1ps
module hwpf_engine_tb;
    reg clk_sys_in = 1'b0, rstn_in = 1'b0, load_miss_in = 1'b0, rfo_miss_in = 1'b0;
    reg swpf_in = 1'b0, l1_access_in = 1'b0, demand_req_in = 1'b0, stall = 1'b0;
    reg [31:0] miss_addr_in = 32'h0, l1_addr_in = 32'h0;
    reg [3:0] bus_q_level_in = 4'h0;
    wire bus_ready_in, l2_ready_in, bus_valid_out, bus_to_l2_out, l1_pf_valid_out;
    wire [31:0] bus_addr_out, l1_pf_addr_out;
    wire [1:0] bus_kind_out;
    wire [7:0] drop_count_out;
    integer mismatches = 0, tests_run = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    hwpf_engine i_dut (
        .clk_sys_in      (clk_sys_in),
        .rstn_in         (rstn_in),
        .load_miss_in    (load_miss_in),
        .rfo_miss_in     (rfo_miss_in),
        .swpf_in         (swpf_in),
        .miss_addr_in    (miss_addr_in),
        .l1_access_in    (l1_access_in),
        .l1_addr_in      (l1_addr_in),
        .demand_req_in   (demand_req_in),
        .bus_q_level_in  (bus_q_level_in),
        .bus_ready_in    (bus_ready_in),
        .l2_ready_in     (l2_ready_in),
        .bus_valid_out   (bus_valid_out),
        .bus_addr_out    (bus_addr_out),
        .bus_kind_out    (bus_kind_out),
        .bus_to_l2_out   (bus_to_l2_out),
        .l1_pf_valid_out (l1_pf_valid_out),
        .l1_pf_addr_out  (l1_pf_addr_out),
        .drop_count_out  (drop_count_out)
    );
    hwpf_mem_model i_mem (.clk_sys_in(clk_sys_in), .stall_in(stall), .valid_in(bus_valid_out),
        .req_in({bus_kind_out, bus_addr_out}), .l1_in(l1_pf_valid_out),
        .ready_out(bus_ready_in), .l2_ok_out(l2_ready_in));
    // ***
    // shared tasks and scenarios
    // ***
    task chk(input [33:0] got, input [33:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    function integer saw(input [33:0] v);
        integer i;
        begin
            saw = 0;
            for (i = 0; i < i_mem.took.size(); i = i + 1) saw = saw + (i_mem.took[i] === v);
        end
    endfunction
    task miss(input [2:0] k, input [31:0] a);
        begin
            @(posedge clk_sys_in);
            {swpf_in, rfo_miss_in, load_miss_in} <= k;
            miss_addr_in <= a;
            @(posedge clk_sys_in);
            {swpf_in, rfo_miss_in, load_miss_in} <= 3'h0;
        end
    endtask
    task drain;
        integer i;
        begin
            repeat (3) @(posedge clk_sys_in);
            for (i = 0; i < 40 && bus_valid_out !== 1'b0; i = i + 1) @(posedge clk_sys_in);
            #1;
        end
    endtask
    // rfo and hint sources advance the same stream as a load
    task trio(input [31:0] a, input [31:0] s, input [31:0] nx, input integer n);
        begin
            miss(3'h1, a);
            miss(3'h2, a + s);
            miss(3'h4, a + s + s);
            drain;
            chk(saw({2'h0, nx}), n);
        end
    endtask
    task t_adj;
        integer k;
        begin
            for (k = 0; k < 3; k = k + 1) begin
                miss(3'h1 << k, 32'h10000 + k * 32'h1044);
                drain;
                chk(saw({2'h1, (32'h10000 + k * 32'h1044) & 32'hFFFFFFC0 ^ 32'h40}), 1);
            end
            chk(bus_to_l2_out, 1);
        end
    endtask
    task t_stream;
        begin
            trio(32'h20000, 32'h40, 32'h200C0, 1);
            trio(32'h30100, 32'hFFFFFFC0, 32'h30040, 1);
            trio(32'h40000, 32'h400, 32'h40C00, 0);
            miss(3'h1, 32'h50000);
            miss(3'h1, 32'h50040);
            drain;
            chk(saw({2'h0, 32'h50080}), 0);
        end
    endtask
    task t_prio;
        begin
            @(posedge clk_sys_in);
            demand_req_in <= 1'b1;
            miss(3'h1, 32'h60000);
            repeat (6) @(posedge clk_sys_in);
            chk(saw({2'h1, 32'h60040}), 0);
            demand_req_in <= 1'b0;
            drain;
            chk(saw({2'h1, 32'h60040}), 1);
        end
    endtask
    task t_drop;
        begin
            @(posedge clk_sys_in);
            stall <= 1'b1;
            miss(3'h1, 32'h70000);
            bus_q_level_in <= 4'hC;
            repeat (3) @(posedge clk_sys_in);
            stall <= 1'b0;
            miss(3'h1, 32'h71000);
            bus_q_level_in <= 4'h0;
            drain;
            chk(drop_count_out, 1);
            chk(saw({2'h1, 32'h70040}) + saw({2'h1, 32'h71040}), 0);
        end
    endtask
    task t_l1;
        begin
            stall <= 1'b1;
            l1_access_in <= 1'b1;
            l1_addr_in <= 32'h2010;
            @(posedge clk_sys_in);
            l1_access_in <= 1'b0;
            repeat (4) @(posedge clk_sys_in);
            chk({l1_pf_valid_out, l1_pf_addr_out}, {1'b1, 32'h2040});
            stall <= 1'b0;
            repeat (4) @(posedge clk_sys_in);
            chk(l1_pf_valid_out, 0);
        end
    endtask
    task give_verdict;
        begin
            $display("tests_run %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        #100000;
        mismatches = mismatches + 1;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        t_adj;
        t_stream;
        t_prio;
        t_drop;
        @(posedge clk_sys_in);
        t_l1;
        give_verdict;
    end
endmodule
